// ### src/local_intc_error_timer_ipi.sv
// Error status, countdown timer and interprocessor message sender, APB slave
// Functional notes
// - Any recorded error raises the error interrupt
// - Flag send and receive checksum errors
// - Flag send and receive accept errors
// - Flag illegal vector in sent message
// - Flag illegal vector in received or local message
// - Flag access to unimplemented register in window
// - Software writes status first; write refreshes contents
// - Two back-to-back status writes clear it
// - Error flags stay set until cleared
// - Error mask stops recording, keeps old status
// - Provide 32-bit down-counting timer with registers
// - Timer ticks at bus clock over divider
// - One-shot: load, count, interrupt once, hold zero
// - Periodic: interrupt at zero, reload, continue
// - Initial count write restarts the countdown
// - Initial count read-write, current count read-only
// - Timer uses entry vector; mask suppresses it
// - Rejected local interrupt retried; accepted is logged
// - Low command word write sends the message
// - Decode message type; some need vector zero; the vector is sent unchecked for those types
// - Destination mode bit; status zero when idle
// - Start-up message is never retried automatically
// - Status one until message accepted by targets
// - Timer mode bit: zero one-shot, one periodic
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module local_intc_error_timer_ipi
  import local_intc_pkg::*;
(
  // Clock and reset
  input  wire logic                        i_clock,
  input  wire logic                        i_nrst,
  // APB slave
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [11:0]                 i_paddr,
  input  wire logic [31:0]                 i_pwdata,
  output logic      [31:0]                 o_prdata,
  output logic                             o_pready,
  output logic                             o_pslverr,
  // Message bus error reports, one-cycle pulses
  input  wire logic                        i_err_send_checksum,
  input  wire logic                        i_err_recv_checksum,
  input  wire logic                        i_err_send_accept,
  input  wire logic                        i_err_recv_accept,
  input  wire logic                        i_err_recv_vector,
  // Outgoing interprocessor message
  output logic                             o_msg_valid,
  output local_intc_pkg::msg_type_t        o_msg_type,
  output logic      [7:0]                  o_msg_vector,
  output logic                             o_msg_dest_logical,
  output logic      [1:0]                  o_msg_shorthand,
  output logic      [7:0]                  o_msg_dest,
  output logic                             o_msg_level,
  output logic                             o_msg_trigger,
  input  wire logic                        i_msg_done,
  input  wire logic                        i_msg_accepted,
  // Local interrupt offer to the core
  output logic                             o_core_req,
  output logic      [7:0]                  o_core_vector,
  input  wire logic                        i_core_accept,
  input  wire logic                        i_core_reject,
  input  wire logic                        i_core_service,
  input  wire logic [7:0]                  i_core_service_vector
);

  typedef struct packed {
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    last_status_write;
    logic [ERR_WIDTH-1:0]    err_latched;
    logic [ERR_WIDTH-1:0]    error_status;
    logic [31:0]             error_entry;
    logic [31:0]             timer_entry;
    logic [31:0]             timer_initial_count;
    logic [31:0]             timer_current_count;
    logic [31:0]             timer_divider_config;
    logic [6:0]              prescale;
    logic                    timer_running;
    logic                    timer_pend;
    logic                    error_pend;
    logic                    offer_timer;
    dlv_state_t              dlv;
    logic [255:0]            pending_request_register;
    logic [31:0]             cmd_low;
    logic [31:0]             cmd_high;
    logic                    cmd_busy;
    logic                    msg_valid;
    logic                    core_req;
    logic [7:0]              core_vector;
  } state_t;

  state_t cur;
  state_t next_cur;

  // Illegal vector check for a type that carries a vector
  function automatic logic vector_illegal(input logic [2:0] mtype, input logic [7:0] vec);
    vector_illegal = ((mtype == MSG_FIXED) || (mtype == MSG_LOWEST)) &&
                     (vec < VECTOR_LEGAL_MIN);
  endfunction

  // Divider code to terminal prescale count
  function automatic logic [6:0] divide_limit(input logic [31:0] cfg);
    logic [2:0] code;
    code = {cfg[3], cfg[1:0]};
    case (code)
      3'b000:  divide_limit = 7'h01;
      3'b001:  divide_limit = 7'h03;
      3'b010:  divide_limit = 7'h07;
      3'b011:  divide_limit = 7'h0F;
      3'b100:  divide_limit = 7'h1F;
      3'b101:  divide_limit = 7'h3F;
      3'b110:  divide_limit = 7'h7F;
      default: divide_limit = 7'h00;
    endcase
  endfunction

  logic                 access;
  logic                 complete;
  logic                 hit;
  logic [31:0]          rd_word;
  logic [ERR_WIDTH-1:0] events;
  logic                 tick;
  logic                 fire;
  logic [2:0]           low_type;

  always_comb begin
    next_cur = cur;
    access   = i_psel && i_penable && !cur.pready;
    complete = i_psel && i_penable && cur.pready;
    hit      = 1'b1;
    rd_word  = 32'h0000_0000;
    events   = '0;
    tick     = 1'b0;
    fire     = 1'b0;
    low_type = i_pwdata[CMD_TYPE_LSB +: 3];

    // Address decode; answer comes one cycle into the access phase
    if (i_paddr >= OFS_PENDING_BASE && i_paddr <= OFS_PENDING_LAST
        && i_paddr[3:0] == 4'h0) begin
      rd_word = cur.pending_request_register[{i_paddr[6:4], 5'h00} +: 32];
    end else if (i_paddr == OFS_ERROR_STATUS) begin
      rd_word = {{(32-ERR_WIDTH){1'b0}}, cur.error_status};
    end else if (i_paddr == OFS_CMD_LOW) begin
      rd_word = cur.cmd_low;
      rd_word[CMD_STATUS_BIT] = cur.cmd_busy;
    end else if (i_paddr == OFS_CMD_HIGH) begin
      rd_word = cur.cmd_high;
    end else if (i_paddr == OFS_TIMER_ENTRY) begin
      rd_word = cur.timer_entry;
      rd_word[ENTRY_STATUS_BIT] = cur.timer_pend;
    end else if (i_paddr == OFS_ERROR_ENTRY) begin
      rd_word = cur.error_entry;
      rd_word[ENTRY_STATUS_BIT] = cur.error_pend;
    end else if (i_paddr == OFS_INITIAL_COUNT) begin
      rd_word = cur.timer_initial_count;
    end else if (i_paddr == OFS_CURRENT_COUNT) begin
      rd_word = cur.timer_current_count;
    end else if (i_paddr == OFS_DIVIDER_CONFIG) begin
      rd_word = cur.timer_divider_config;
    end else begin
      hit = 1'b0;
    end

    next_cur.pready = access;
    if (access) begin
      next_cur.prdata  = i_pwrite ? 32'h0000_0000 : rd_word;
      next_cur.pslverr = !hit;
    end else begin
      next_cur.prdata  = 32'h0000_0000;
      next_cur.pslverr = 1'b0;
    end

    // Error sources
    events[ERR_SEND_CHECKSUM] = i_err_send_checksum;
    events[ERR_RECV_CHECKSUM] = i_err_recv_checksum;
    events[ERR_SEND_ACCEPT]   = i_err_send_accept;
    events[ERR_RECV_ACCEPT]   = i_err_recv_accept;
    events[ERR_RECV_VECTOR]   = i_err_recv_vector;
    events[ERR_REG_ADDRESS]   = complete && !hit;

    // Prescaler runs always; a divider change takes effect when the count next equals the new limit
    tick = (cur.prescale == divide_limit(cur.timer_divider_config));
    next_cur.prescale = tick ? 7'h00 : cur.prescale + 7'h01;

    // Countdown
    if (cur.timer_running && tick) begin
      next_cur.timer_current_count = cur.timer_current_count - 32'h0000_0001;
      if (cur.timer_current_count == 32'h0000_0001) begin
        fire = 1'b1;
        if (cur.timer_entry[ENTRY_MODE_BIT]) begin
          next_cur.timer_current_count = cur.timer_initial_count;
        end else begin
          next_cur.timer_running = 1'b0;
        end
      end
    end

    if (fire && !cur.timer_entry[ENTRY_MASK_BIT]) begin
      next_cur.timer_pend = 1'b1;
      if (vector_illegal(MSG_FIXED, cur.timer_entry[7:0])) begin
        events[ERR_RECV_VECTOR] = 1'b1;
      end
    end

    // Message completion; a failed delivery leaves status set, no retry
    if (i_msg_done && i_msg_accepted) begin
      next_cur.cmd_busy = 1'b0;
    end
    next_cur.msg_valid = 1'b0;

    // Register writes take effect at the edge where pready is seen
    if (complete && i_pwrite) begin
      if (i_paddr == OFS_ERROR_STATUS) begin
        if (cur.last_status_write) begin
          next_cur.err_latched  = '0;
          next_cur.error_status = '0;
        end else begin
          next_cur.error_status = cur.err_latched;
        end
      end else if (i_paddr == OFS_CMD_LOW) begin
        next_cur.cmd_low   = i_pwdata & CMD_LOW_WRITE_MASK;
        next_cur.cmd_busy  = 1'b1;
        next_cur.msg_valid = 1'b1;
        if (vector_illegal(low_type, i_pwdata[7:0])) begin
          events[ERR_SEND_VECTOR] = 1'b1;
        end
      end else if (i_paddr == OFS_CMD_HIGH) begin
        next_cur.cmd_high = {i_pwdata[31:CMD_DEST_LSB], 24'h00_0000};
      end else if (i_paddr == OFS_TIMER_ENTRY) begin
        next_cur.timer_entry = i_pwdata & ENTRY_WRITE_MASK;
        if (vector_illegal(MSG_FIXED, i_pwdata[7:0])) begin
          events[ERR_RECV_VECTOR] = 1'b1;
        end
      end else if (i_paddr == OFS_ERROR_ENTRY) begin
        next_cur.error_entry = i_pwdata & ENTRY_WRITE_MASK & ~(32'h1 << ENTRY_MODE_BIT);
        if (vector_illegal(MSG_FIXED, i_pwdata[7:0])) begin
          events[ERR_RECV_VECTOR] = 1'b1;
        end
      end else if (i_paddr == OFS_INITIAL_COUNT) begin
        next_cur.timer_initial_count = i_pwdata;
        next_cur.timer_current_count = i_pwdata;
        next_cur.timer_running = (i_pwdata != 32'h0000_0000);
        next_cur.prescale = 7'h00;
      end else if (i_paddr == OFS_DIVIDER_CONFIG) begin
        next_cur.timer_divider_config = i_pwdata & DIV_WRITE_MASK;
      end
    end
    if (complete) begin
      next_cur.last_status_write = i_pwrite && (i_paddr == OFS_ERROR_STATUS);
    end

    // Record errors unless masked; set wins over a clear in the same cycle
    if (!cur.error_entry[ENTRY_MASK_BIT]) begin
      next_cur.err_latched = next_cur.err_latched | events;
      if (events != '0) begin
        next_cur.error_pend = 1'b1;
      end
    end

    // Offer pending local interrupts to the core, timer first
    next_cur.core_req = 1'b0;
    case (cur.dlv)
      DLV_IDLE: begin
        if (cur.timer_pend || cur.error_pend) begin
          next_cur.offer_timer = cur.timer_pend;
          next_cur.core_vector = cur.timer_pend ? cur.timer_entry[7:0] :
                                 cur.error_entry[7:0];
          next_cur.core_req = 1'b1;
          next_cur.dlv = DLV_OFFER;
        end
      end
      DLV_OFFER: begin
        if (i_core_accept) begin
          next_cur.pending_request_register[cur.core_vector] = 1'b1;
          if (cur.offer_timer) begin
            next_cur.timer_pend = fire && !cur.timer_entry[ENTRY_MASK_BIT];
          end else begin
            next_cur.error_pend = next_cur.error_pend && (events != '0)
                                  && !cur.error_entry[ENTRY_MASK_BIT];
          end
          next_cur.dlv = DLV_IDLE;
        end else if (i_core_reject) begin
          next_cur.dlv = DLV_WAIT;
        end else begin
          next_cur.core_req = 1'b1;
        end
      end
      default: begin
        // Two cycles with no request before the retry offer
        next_cur.dlv = DLV_IDLE;
      end
    endcase

    // Core services a logged vector; a new log in the same cycle wins
    if (i_core_service && !(cur.dlv == DLV_OFFER && i_core_accept
                            && cur.core_vector == i_core_service_vector)) begin
      next_cur.pending_request_register[i_core_service_vector] = 1'b0;
    end

    if (!i_nrst) begin
      next_cur = '0;
      next_cur.error_entry = ENTRY_RESET;
      next_cur.timer_entry = ENTRY_RESET;
      next_cur.dlv = DLV_IDLE;
    end
  end

  always_ff @(posedge i_clock) begin
    cur <= next_cur;
  end

  // Outputs straight from state flip-flops
  assign o_prdata           = cur.prdata;
  assign o_pready           = cur.pready;
  assign o_pslverr          = cur.pslverr;
  assign o_msg_valid        = cur.msg_valid;
  assign o_msg_type         = msg_type_t'(cur.cmd_low[CMD_TYPE_LSB +: 3]);
  assign o_msg_vector       = cur.cmd_low[7:0];
  assign o_msg_dest_logical = cur.cmd_low[CMD_DEST_MODE_BIT];
  assign o_msg_shorthand    = cur.cmd_low[CMD_SHORT_LSB +: 2];
  assign o_msg_dest         = cur.cmd_high[CMD_DEST_LSB +: 8];
  assign o_msg_level        = cur.cmd_low[CMD_LEVEL_BIT];
  assign o_msg_trigger      = cur.cmd_low[CMD_TRIGGER_BIT];
  assign o_core_req         = cur.core_req;
  assign o_core_vector      = cur.core_vector;

endmodule

// ### src/local_intc_pkg.sv
// Constants and types for the local interrupt unit error, timer and message block
package local_intc_pkg;

  // Register byte offsets inside the 4K register window
  localparam logic [11:0] OFS_PENDING_BASE   = 12'h200;
  localparam logic [11:0] OFS_PENDING_LAST   = 12'h270;
  localparam logic [11:0] OFS_ERROR_STATUS   = 12'h280;
  localparam logic [11:0] OFS_CMD_LOW        = 12'h300;
  localparam logic [11:0] OFS_CMD_HIGH       = 12'h310;
  localparam logic [11:0] OFS_TIMER_ENTRY    = 12'h320;
  localparam logic [11:0] OFS_ERROR_ENTRY    = 12'h370;
  localparam logic [11:0] OFS_INITIAL_COUNT  = 12'h380;
  localparam logic [11:0] OFS_CURRENT_COUNT  = 12'h390;
  localparam logic [11:0] OFS_DIVIDER_CONFIG = 12'h3E0;

  // Error status bit positions
  localparam int ERR_SEND_CHECKSUM = 0;
  localparam int ERR_RECV_CHECKSUM = 1;
  localparam int ERR_SEND_ACCEPT   = 2;
  localparam int ERR_RECV_ACCEPT   = 3;
  localparam int ERR_SEND_VECTOR   = 5;
  localparam int ERR_RECV_VECTOR   = 6;
  localparam int ERR_REG_ADDRESS   = 7;
  localparam int ERR_WIDTH         = 8;

  // Table entry fields (timer and error entries)
  localparam int ENTRY_STATUS_BIT  = 12;
  localparam int ENTRY_MASK_BIT    = 16;
  localparam int ENTRY_MODE_BIT    = 17;
  localparam logic [31:0] ENTRY_WRITE_MASK = 32'h0003_00FF;
  localparam logic [31:0] ENTRY_RESET      = 32'h0001_0000;

  // Command register low word fields, destination in high word
  localparam int CMD_TYPE_LSB      = 8;
  localparam int CMD_DEST_MODE_BIT = 11;
  localparam int CMD_STATUS_BIT    = 12;
  localparam int CMD_LEVEL_BIT     = 14;
  localparam int CMD_TRIGGER_BIT   = 15;
  localparam int CMD_SHORT_LSB     = 18;
  localparam int CMD_DEST_LSB      = 24;
  localparam logic [31:0] CMD_LOW_WRITE_MASK = 32'h000C_CFFF;

  // Divider configuration uses bits 3,1,0
  localparam logic [31:0] DIV_WRITE_MASK = 32'h0000_000B;

  // Vectors below this value are illegal
  localparam logic [7:0] VECTOR_LEGAL_MIN = 8'h10;

  typedef enum logic [2:0] {
    MSG_FIXED    = 3'b000,
    MSG_LOWEST   = 3'b001,
    MSG_SYS_MGMT = 3'b010,
    MSG_RESERVED = 3'b011,
    MSG_NMI      = 3'b100,
    MSG_INIT     = 3'b101,
    MSG_STARTUP  = 3'b110,
    MSG_EXTERNAL = 3'b111
  } msg_type_t;

  typedef enum logic [1:0] {
    DLV_IDLE,
    DLV_OFFER,
    DLV_WAIT
  } dlv_state_t;

endpackage

// ### dv/local_intc_error_timer_ipi_monitor.sv
// Port-level checker for the error, timer and message block
`timescale 1ns/10ps
module local_intc_error_timer_ipi_monitor
  import local_intc_pkg::*;
(
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_nrst,
  // Register bus
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // Message and core
  input wire logic        o_msg_valid,
  input wire msg_type_t   o_msg_type,
  input wire logic [7:0]  o_msg_vector,
  input wire logic        o_core_req,
  input wire logic [7:0]  o_core_vector,
  input wire logic        i_core_accept,
  input wire logic        i_core_reject
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  pready_wait_a: assert property ($rose(i_penable) && i_psel |=> o_pready)
    else $error("ready not one cycle after enable");
  slverr_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("slave error outside a completion");
  msg_send_a: assert property (i_psel && i_penable && i_pwrite && o_pready
    && i_paddr == OFS_CMD_LOW |=> o_msg_valid) else $error("low word write sent nothing");
  msg_only_a: assert property (o_msg_valid |-> $past(i_psel && i_pwrite && o_pready
    && i_paddr == OFS_CMD_LOW)) else $error("message without low word write");
  msg_fields_a: assert property (o_msg_valid |-> o_msg_vector == $past(i_pwdata[7:0])
    && o_msg_type == $past(i_pwdata[10:8])) else $error("message fields differ");
  offer_hold_a: assert property (o_core_req && !i_core_accept && !i_core_reject
    |=> o_core_req && $stable(o_core_vector)) else $error("offer dropped unanswered");
  accept_drop_a: assert property (o_core_req && i_core_accept |=> !o_core_req)
    else $error("offer held after accept");
  reject_retry_a: assert property (o_core_req && i_core_reject
    |=> !o_core_req [*2] ##[1:4] o_core_req) else $error("rejected offer not retried");
endmodule

bind local_intc_error_timer_ipi local_intc_error_timer_ipi_monitor monitor_i (.*);

// ### dv/local_intc_peer_model.sv
// Far-side model: peer processors on the message bus and the local core
`timescale 1ns/10ps
module local_intc_peer_model (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  // From the block
  input  wire logic       i_msg_valid,
  input  wire logic       i_core_req,
  // Scenario controls
  input  wire logic       i_msg_nak,
  input  wire logic       i_core_nak,
  // To the block
  output logic            o_msg_done,
  output logic            o_msg_accepted,
  output logic            o_core_accept,
  output logic            o_core_reject,
  output logic            o_core_service,
  output logic      [7:0] o_core_service_vector
);
  logic [2:0] msg_wait;
  logic [1:0] core_wait;
  assign o_core_service = 1'b0;
  assign o_core_service_vector = 8'h00;
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      msg_wait <= 3'h0;
      o_msg_done <= 1'b0;
      o_msg_accepted <= 1'b0;
      core_wait <= 2'h0;
      o_core_accept <= 1'b0;
      o_core_reject <= 1'b0;
    end else begin
      o_msg_done <= (msg_wait == 3'h1);
      // Result means nothing outside done, so it keeps changing there
      o_msg_accepted <= (msg_wait == 3'h1) ? !i_msg_nak : !o_msg_accepted;
      msg_wait <= i_msg_valid ? 3'h3 : msg_wait - (msg_wait != 3'h0);
      if (o_core_accept || o_core_reject) begin
        o_core_accept <= 1'b0;
        o_core_reject <= 1'b0;
        core_wait <= 2'h0;
      end else if (i_core_req && core_wait == 2'h2) begin
        o_core_accept <= !i_core_nak;
        o_core_reject <= i_core_nak;
      end else begin
        core_wait <= i_core_req ? core_wait + 2'h1 : 2'h0;
      end
    end
  end
endmodule

// ### dv/local_intc_error_timer_ipi_tb_top.sv
// Self-checking bench for the error, timer and message block
`timescale 1ns/10ps
module local_intc_error_timer_ipi_tb_top;
  import local_intc_pkg::*;
  typedef struct packed {msg_type_t ty; logic [7:0] vec; logic lg;} row_t;
  logic        i_clock = 0, i_nrst = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, q, w;
  logic        o_pready, o_pslverr, o_msg_valid, o_msg_dest_logical, o_msg_level;
  logic        o_msg_trigger, i_msg_done, i_msg_accepted, o_core_req, i_core_accept;
  logic        i_core_reject, i_core_service, e, seen_log, req_d = 0;
  msg_type_t   o_msg_type, seen_type;
  logic [7:0]  o_msg_vector, o_msg_dest, o_core_vector, i_core_service_vector;
  logic [7:0]  seen_vec, seen_dest, last_vec;
  logic [1:0]  o_msg_shorthand;
  logic        i_err_send_checksum = 0, i_err_recv_checksum = 0, i_err_send_accept = 0;
  logic        i_err_recv_accept = 0, i_err_recv_vector = 0, msg_nak = 0, core_nak = 0;
  int          miscompares = 0, n_checks = 0, cycles = 0, seen = 0, offers = 0, k, o0;
  row_t        rows [7] = '{'{MSG_FIXED, 8'h30, 1'b0}, '{MSG_LOWEST, 8'h31, 1'b1},
    '{MSG_SYS_MGMT, 8'h00, 1'b0}, '{MSG_NMI, 8'h00, 1'b1}, '{MSG_INIT, 8'h00, 1'b0},
    '{MSG_STARTUP, 8'h20, 1'b0}, '{MSG_FIXED, 8'h05, 1'b0}};

  local_intc_error_timer_ipi local_intc_error_timer_ipi_i (.*);
  local_intc_peer_model local_intc_peer_model_i (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_msg_valid(o_msg_valid), .i_core_req(o_core_req), .i_msg_nak(msg_nak),
    .i_core_nak(core_nak), .o_msg_done(i_msg_done), .o_msg_accepted(i_msg_accepted),
    .o_core_accept(i_core_accept), .o_core_reject(i_core_reject),
    .o_core_service(i_core_service), .o_core_service_vector(i_core_service_vector));

  always #10 i_clock = ~i_clock;
  // Sampled at the falling edge, where all registered outputs have settled
  always @(negedge i_clock) begin
    if (o_msg_valid === 1'b1) begin
      seen++;
      {seen_type, seen_vec, seen_log, seen_dest} = {o_msg_type, o_msg_vector,
        o_msg_dest_logical, o_msg_dest};
    end
    if (o_core_req === 1'b1 && req_d !== 1'b1) begin
      offers++;
      last_vec = o_core_vector;
    end
    req_d = o_core_req;
  end
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Entered just after a rising edge; holds the request until ready is sampled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input bit more);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    // Data and error are taken at the very edge that samples ready high
    do begin
      @(posedge i_clock);
    end while (o_pready !== 1'b1);
    q = o_prdata;
    e = o_pslverr;
    i_penable <= 1'b0;
    if (!more) begin
      i_psel <= 1'b0;
      @(posedge i_clock);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(q, exp);
  endtask
  task automatic pulse(input logic [4:0] m);
    {i_err_send_checksum, i_err_recv_checksum, i_err_send_accept, i_err_recv_accept,
      i_err_recv_vector} <= m;
    @(posedge i_clock);
    {i_err_send_checksum, i_err_recv_checksum, i_err_send_accept, i_err_recv_accept,
      i_err_recv_vector} <= 5'h00;
    @(posedge i_clock);
  endtask
  task automatic wait_offer(input int n0, output int c);
    c = 0;
    while (offers == n0 && c < 3000) begin
      @(posedge i_clock);
      c++;
    end
  endtask

  initial begin
    repeat (16) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock);
    for (int r = 0; r < 7; r++) begin
      w = {12'h0, 2'(r), 2'b00, r[0], 3'b100, rows[r].lg, rows[r].ty, rows[r].vec};
      o0 = seen;
      wr(OFS_CMD_HIGH, {8'(r + 1), 24'h0});
      wr(OFS_CMD_LOW, w);
      chk(seen, o0 + 1);
      chk({o_msg_trigger, o_msg_level, o_msg_shorthand}, {r[0], 1'b1, 2'(r)});
      chk(seen_type, rows[r].ty);
      chk({seen_log, seen_vec, seen_dest}, {rows[r].lg, rows[r].vec, 8'(r + 1)});
      repeat (6) @(posedge i_clock);
      rd(OFS_CMD_LOW, w);
    end
    rd(OFS_TIMER_ENTRY, ENTRY_RESET);
    rd(OFS_CURRENT_COUNT, 32'h0);
    apb(1'b0, 12'h3F0, 32'h0, 1'b0);
    chk({e, q}, {1'b1, 32'h0});
    wr(OFS_ERROR_STATUS, 32'h0);
    rd(OFS_ERROR_STATUS, 32'h0);
    wr(OFS_ERROR_ENTRY, 32'h40);
    o0 = offers;
    pulse(5'h1F);
    apb(1'b0, 12'h3F0, 32'h0, 1'b0);
    wait_offer(o0, k);
    chk(last_vec, 8'h40);
    wr(OFS_ERROR_STATUS, 32'h0);
    rd(OFS_ERROR_STATUS, 32'hCF);
    wr(OFS_ERROR_STATUS, 32'h0);
    rd(OFS_ERROR_STATUS, 32'hCF);
    apb(1'b1, OFS_ERROR_STATUS, 32'h0, 1'b1);
    wr(OFS_ERROR_STATUS, 32'h0);
    wr(OFS_ERROR_STATUS, 32'h0);
    rd(OFS_ERROR_STATUS, 32'h0);
    pulse(5'h02);
    wr(OFS_ERROR_STATUS, 32'h0);
    rd(OFS_ERROR_STATUS, 32'h08);
    wr(OFS_ERROR_ENTRY, 32'h0001_0040);
    pulse(5'h08);
    wr(OFS_ERROR_STATUS, 32'h0);
    rd(OFS_ERROR_STATUS, 32'h08);
    // Timer at full bus rate; the first offer is refused once
    wr(OFS_DIVIDER_CONFIG, 32'hB);
    wr(OFS_TIMER_ENTRY, 32'h50);
    core_nak <= 1'b1;
    o0 = offers;
    wr(OFS_INITIAL_COUNT, 32'd20);
    wait_offer(o0, k);
    chk(k >= 18 && k <= 26, 1'b1);
    // The refusal is only lifted once the core side has answered the offer
    while (i_core_reject !== 1'b1) begin
      @(posedge i_clock);
    end
    core_nak <= 1'b0;
    wait_offer(o0 + 1, k);
    chk({k < 10, last_vec}, {1'b1, 8'h50});
    rd(OFS_INITIAL_COUNT, 32'd20);
    rd(OFS_CURRENT_COUNT, 32'h0);
    o0 = offers;
    repeat (30) @(posedge i_clock);
    chk(offers, o0);
    rd(OFS_PENDING_BASE + 12'h020, 32'h0001_0001);
    wr(OFS_TIMER_ENTRY, 32'h0002_0050);
    o0 = offers;
    wr(OFS_INITIAL_COUNT, 32'd16);
    repeat (72) @(posedge i_clock);
    chk(offers, o0 + 4);
    wr(OFS_TIMER_ENTRY, 32'h50);
    wr(OFS_INITIAL_COUNT, 32'd1000);
    repeat (5) @(posedge i_clock);
    o0 = offers;
    wr(OFS_INITIAL_COUNT, 32'd30);
    wait_offer(o0, k);
    chk(k >= 28 && k <= 36, 1'b1);
    wr(OFS_DIVIDER_CONFIG, 32'h1);
    o0 = offers;
    wr(OFS_INITIAL_COUNT, 32'd10);
    wait_offer(o0, k);
    chk(k >= 38 && k <= 48, 1'b1);
    wr(OFS_CURRENT_COUNT, 32'h1234);
    rd(OFS_CURRENT_COUNT, 32'h0);
    // Errors were masked by the last error entry write, so unmask before sending a bad vector
    wr(OFS_ERROR_ENTRY, 32'h40);
    wr(OFS_CMD_LOW, 32'h0000_4005);
    wr(OFS_ERROR_STATUS, 32'h0);
    rd(OFS_ERROR_STATUS, 32'h28);
    // Start-up message refused by every peer is left to software
    msg_nak <= 1'b1;
    o0 = seen;
    w = 32'h0000_4620;
    wr(OFS_CMD_LOW, w);
    repeat (10) @(posedge i_clock);
    rd(OFS_CMD_LOW, w | 32'h1000);
    chk(seen, o0 + 1);
    msg_nak <= 1'b0;
    wr(OFS_CMD_LOW, w);
    repeat (6) @(posedge i_clock);
    rd(OFS_CMD_LOW, w);
    // Reset in mid-run puts the entries back to masked and the command idle
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock);
    rd(OFS_TIMER_ENTRY, ENTRY_RESET);
    rd(OFS_CMD_LOW, 32'h0);
    tally_and_finish();
  end
endmodule
